// >>> dsq_defines.svh
// constants for the drive sequencing block
`ifndef DSQ_DEFINES_SVH
`define DSQ_DEFINES_SVH

`define DSQ_CLK_MHZ 250
`define DSQ_TRIP_MS 15
`define DSQ_TRIP_CYC (`DSQ_TRIP_MS * 1000 * `DSQ_CLK_MHZ)
`define DSQ_SYNC_IDLE 16'h00C0

// register byte offsets
`define DSQ_A_CTRL 12'h000
`define DSQ_A_FSEL 12'h004
`define DSQ_A_INV 12'h008
`define DSQ_A_BOPEN 12'h00C
`define DSQ_A_FRDLY 12'h010
`define DSQ_A_DLY0 12'h014
`define DSQ_A_STAT 12'h024
`define DSQ_A_SFV 12'h028
`define DSQ_A_CLAMP 12'h02C

// ctrl register fields
`define DSQ_CTRL_BTYPE_LSB 0
`define DSQ_CTRL_FMODE_LSB 2
`define DSQ_CTRL_ESTOP_PB 4
`define DSQ_CTRL_OPTRUN 5

// brake types and field mode
`define DSQ_BT_HOLD 2'h1
`define DSQ_BT_OPER 2'h2
`define DSQ_FM_AUTO 2'h2

// output selector codes
`define DSQ_F_LOW 6'h00
`define DSQ_F_HIGH 6'h01
`define DSQ_F_SET 6'h02
`define DSQ_F_FAULT 6'h03
`define DSQ_F_RTSO 6'h04
`define DSQ_F_READY 6'h05
`define DSQ_F_RUN 6'h06
`define DSQ_F_AUX 6'h07
`define DSQ_F_SUPPLY 6'h08
`define DSQ_F_INHIB 6'h09
`define DSQ_F_ESTOP 6'h0A
`define DSQ_F_CHKB 6'h0B
`define DSQ_F_RAMP 6'h0C
`define DSQ_F_CCW 6'h0D
`define DSQ_F_BRAKE 6'h0E
`define DSQ_F_NX1 6'h10
`define DSQ_F_NMIN 6'h15

`define DSQ_ZERO32 32'h0000_0000
`endif

// >>> dsq_pkg.sv
// types of the drive sequencing block
package dsq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_BRAKEWAIT, ST_RUN, ST_STOPI, ST_OFF, ST_ESTOP
    } dsq_state_e;

    typedef struct packed {
        logic [5:0] nBelow;
        logic rampActive;
        logic ccw;
        logic currentZero;
        logic supply;
        logic auxOn;
        logic chkback;
        logic fault;
    } dsq_plant_s;

    typedef struct packed {
        logic ctrlEnable;
        logic setpointZero;
        logic pulseBlock;
        logic lineContactor;
        logic contactorTrip;
        logic fieldReduce;
        logic fieldClamp;
    } dsq_drive_s;
endpackage

// >>> dsq_out_filter.sv
// one binary select output: decode, invert, stability delay
`timescale 1ns/100ps
`include "dsq_defines.svh"
module dsq_out_filter (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] funcSel,
    input wire logic invert,
    input wire logic [31:0] delayCyc,
    input wire logic [63:0] sources,
    output logic level
);
    logic rawLvl;
    logic [31:0] stableCnt_ff;
    logic lastRaw_ff;
    logic level_ff;

    assign rawLvl = sources[funcSel] ^ invert;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lastRaw_ff <= 1'b0;
        end else begin
            lastRaw_ff <= rawLvl;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stableCnt_ff <= `DSQ_ZERO32;
            level_ff <= 1'b0;
        end else if (rawLvl != lastRaw_ff) begin
            stableCnt_ff <= `DSQ_ZERO32;
        end else if (stableCnt_ff >= delayCyc) begin
            level_ff <= rawLvl;
        end else begin
            stableCnt_ff <= stableCnt_ff + 32'h0000_0001;
        end
    end

    assign level = level_ff;
endmodule

// >>> dsq_drive_seq.sv
// drive sequencing: permission, brake, field, e-stop, select outputs
`timescale 1ns/100ps
`include "dsq_defines.svh"
// Functional notes
// - positive brake time: open brake, wait, then enable controllers
// - negative brake time: enable at once, open brake after it
// - permission loss: inhibit, zero setpoint, block pulses at zero current
// - operating brake closes after pulse block, then ready status or higher
// - holding brake closes only below minimum speed
// - all permission sources are ANDed
// - auto field mode: delay in off, then standstill field
// - switch-on cancels auto field reduction on leaving off
// - standstill field input level 1 reduces field immediately
// - standstill command ignored during optimization run
// - pushbutton mode latches e-stop until reset; switch mode direct
// - e-stop inhibits, zeroes setpoint, blocks pulses, closes operating brake
// - e-stop clamps field limit to past value until status o5 or lower
// - e-stop drops contactor, runs field delay, holding brake below minimum
// - e-stop acts as coast stop; contactor tripped 15 ms later
// - four select outputs, own selector each
// - each selected function optionally inverted
// - output changes only after level stable for its delay
// - codes 0 to 8: low, high, set, fault, status signals
// - codes 9 to 14: inhibit, estop, checkback, ramp, ccw, brake
// - codes 16 to 21 speed-below comparisons, 21 minimum speed
// - fault output low in fault status; status word bit inverted
// - brake output high opens, low closes
module dsq_drive_seq (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] switchOnPins,
    input wire logic [3:0] operEnablePins,
    input wire logic estopSwitchPin,
    input wire logic estopStopNcPin,
    input wire logic estopResetNoPin,
    input wire logic standstill_field_input,
    input wire logic [3:0] setOutputPins,
    input wire dsq_pkg::dsq_plant_s plant,
    output dsq_pkg::dsq_drive_s drive,
    output logic brake_release_output,
    output logic [3:0] selectOut,
    output logic [15:0] drive_status_word
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] pinRaw, syncA_ff, syncB_ff;
    assign pinRaw = {switchOnPins, operEnablePins, estopSwitchPin, estopStopNcPin, estopResetNoPin,
                     standstill_field_input, setOutputPins};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_ff <= `DSQ_SYNC_IDLE;
            syncB_ff <= `DSQ_SYNC_IDLE;
        end else begin
            syncA_ff <= pinRaw;
            syncB_ff <= syncA_ff;
        end
    end
    logic [3:0] swOn, opEn, setOut;
    logic eSw, eStopNc, eResetNo, ssField;
    assign {swOn, opEn, eSw, eStopNc, eResetNo, ssField, setOut} = syncB_ff;

    ////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    logic [31:0] ctrl_ff, fsel_ff, inv_ff, bopen_ff, frdly_ff, sfv_ff;
    logic [31:0] dly_ff [4];
    logic [31:0] clamp_ff;
    logic wrPend_ff, rdPend_ff;
    logic [11:0] addr_ff;
    logic [31:0] statusReg;
    logic accept;
    assign accept = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else begin
            wrPend_ff <= accept & hwrite;
            rdPend_ff <= accept & ~hwrite;
            addr_ff <= haddr[11:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= {28'h000_0000, `DSQ_FM_AUTO, `DSQ_BT_HOLD};
            fsel_ff <= {2'h0, `DSQ_F_SET, 2'h0, `DSQ_F_SET, 2'h0, `DSQ_F_SET, 2'h0, `DSQ_F_FAULT};
            inv_ff <= `DSQ_ZERO32;
            bopen_ff <= `DSQ_ZERO32;
            frdly_ff <= `DSQ_ZERO32;
            sfv_ff <= `DSQ_ZERO32;
            for (int i = 0; i < 4; i++) begin
                dly_ff[i] <= `DSQ_ZERO32;
            end
        end else if (wrPend_ff) begin
            case (addr_ff)
                `DSQ_A_CTRL: ctrl_ff <= hwdata;
                `DSQ_A_FSEL: fsel_ff <= hwdata;
                `DSQ_A_INV: inv_ff <= hwdata;
                `DSQ_A_BOPEN: bopen_ff <= hwdata;
                `DSQ_A_FRDLY: frdly_ff <= hwdata;
                `DSQ_A_SFV: sfv_ff <= hwdata;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (addr_ff == `DSQ_A_DLY0 + 12'(4 * i)) begin
                            dly_ff[i] <= hwdata;
                        end
                    end
                end
            endcase
        end
    end

    logic [31:0] nxt_hrdata;
    always_comb begin
        nxt_hrdata = `DSQ_ZERO32;
        case (addr_ff)
            `DSQ_A_CTRL: nxt_hrdata = ctrl_ff;
            `DSQ_A_FSEL: nxt_hrdata = fsel_ff;
            `DSQ_A_INV: nxt_hrdata = inv_ff;
            `DSQ_A_BOPEN: nxt_hrdata = bopen_ff;
            `DSQ_A_FRDLY: nxt_hrdata = frdly_ff;
            `DSQ_A_STAT: nxt_hrdata = statusReg;
            `DSQ_A_SFV: nxt_hrdata = sfv_ff;
            `DSQ_A_CLAMP: nxt_hrdata = clamp_ff;
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (addr_ff == `DSQ_A_DLY0 + 12'(4 * i)) begin
                        nxt_hrdata = dly_ff[i];
                    end
                end
            end
        endcase
    end
    // zero-wait read data, data phase only
    assign hrdata = rdPend_ff ? nxt_hrdata : `DSQ_ZERO32;

    logic [1:0] brakeType, fieldMode;
    logic pbMode, optRun;
    assign brakeType = ctrl_ff[`DSQ_CTRL_BTYPE_LSB +: 2];
    assign fieldMode = ctrl_ff[`DSQ_CTRL_FMODE_LSB +: 2];
    assign pbMode = ctrl_ff[`DSQ_CTRL_ESTOP_PB];
    assign optRun = ctrl_ff[`DSQ_CTRL_OPTRUN];

    ////////////////////////////////////////////////////////////////
    // permission and e-stop
    logic switchOn, operEnable, estopLatch_ff, estop;
    assign switchOn = &swOn;
    assign operEnable = &opEn;

    // pushbutton latch; stop wins over reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            estopLatch_ff <= 1'b0;
        end else if (!eStopNc) begin
            estopLatch_ff <= 1'b1;
        end else if (eResetNo) begin
            estopLatch_ff <= 1'b0;
        end
    end
    assign estop = pbMode ? estopLatch_ff : ~eSw;

    ////////////////////////////////////////////////////////////////
    // sequence state machine
    dsq_pkg::dsq_state_e state_ff;
    logic [31:0] timer_ff, absOpen;
    logic bopenNeg, brakeOpen_ff, nMin, nMinSeen_ff;
    assign bopenNeg = bopen_ff[31];
    assign absOpen = bopenNeg ? (~bopen_ff + 32'h0000_0001) : bopen_ff;
    assign nMin = plant.nBelow[5];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= dsq_pkg::ST_OFF;
            timer_ff <= `DSQ_ZERO32;
        end else begin
            timer_ff <= timer_ff + 32'h0000_0001;
            case (state_ff)
                dsq_pkg::ST_OFF: begin
                    if (estop) begin
                        state_ff <= dsq_pkg::ST_ESTOP;
                    end else if (switchOn) begin
                        state_ff <= dsq_pkg::ST_IDLE;
                    end
                end
                dsq_pkg::ST_IDLE: begin
                    timer_ff <= `DSQ_ZERO32;
                    if (estop) begin
                        state_ff <= dsq_pkg::ST_STOPI;
                    end else if (!switchOn) begin
                        state_ff <= dsq_pkg::ST_OFF;
                    end else if (operEnable) begin
                        state_ff <= bopenNeg ? dsq_pkg::ST_RUN : dsq_pkg::ST_BRAKEWAIT;
                    end
                end
                dsq_pkg::ST_BRAKEWAIT: begin
                    if (!operEnable || estop || !switchOn) begin
                        state_ff <= dsq_pkg::ST_STOPI;
                    end else if (timer_ff >= absOpen) begin
                        state_ff <= dsq_pkg::ST_RUN;
                        timer_ff <= `DSQ_ZERO32;
                    end
                end
                dsq_pkg::ST_RUN: begin
                    if (!operEnable || estop || !switchOn) begin
                        state_ff <= dsq_pkg::ST_STOPI;
                    end
                end
                dsq_pkg::ST_STOPI: begin
                    timer_ff <= `DSQ_ZERO32;
                    if (plant.currentZero) begin
                        state_ff <= estop ? dsq_pkg::ST_ESTOP : (switchOn ? dsq_pkg::ST_IDLE : dsq_pkg::ST_OFF);
                    end
                end
                dsq_pkg::ST_ESTOP: begin
                    if (!estop) begin
                        state_ff <= dsq_pkg::ST_OFF;
                    end
                end
                default: state_ff <= dsq_pkg::ST_OFF;
            endcase
        end
    end

    // holding brake interlock after first standstill
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nMinSeen_ff <= 1'b0;
        end else if (state_ff == dsq_pkg::ST_RUN || state_ff == dsq_pkg::ST_BRAKEWAIT) begin
            nMinSeen_ff <= 1'b0;
        end else if (nMin) begin
            nMinSeen_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brakeOpen_ff <= 1'b0;
        end else begin
            case (state_ff)
                dsq_pkg::ST_BRAKEWAIT: brakeOpen_ff <= 1'b1;
                dsq_pkg::ST_RUN: brakeOpen_ff <= brakeOpen_ff | ~bopenNeg | (timer_ff >= absOpen);
                default: begin
                    if (brakeType == `DSQ_BT_OPER && state_ff != dsq_pkg::ST_STOPI) begin
                        brakeOpen_ff <= 1'b0;
                    end else if (brakeType != `DSQ_BT_OPER && (nMin || nMinSeen_ff)) begin
                        brakeOpen_ff <= 1'b0;
                    end
                end
            endcase
        end
    end
    // e-stop uses the same brake path
    assign brake_release_output = brakeOpen_ff;

    ////////////////////////////////////////////////////////////////
    // field reduction, clamp and contactor trip
    logic [31:0] frTimer_ff, tripTimer_ff;
    logic autoReduce_ff, clamp_q, trip_ff, offStatus;
    assign offStatus = (state_ff == dsq_pkg::ST_OFF) || (state_ff == dsq_pkg::ST_ESTOP);

    // delay then reduce; cancelled on leaving off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frTimer_ff <= `DSQ_ZERO32;
            autoReduce_ff <= 1'b0;
        end else if (!offStatus || fieldMode != `DSQ_FM_AUTO) begin
            frTimer_ff <= `DSQ_ZERO32;
            autoReduce_ff <= 1'b0;
        // field delay also runs after e-stop
        end else if (frTimer_ff >= frdly_ff) begin
            autoReduce_ff <= 1'b1;
        end else begin
            frTimer_ff <= frTimer_ff + 32'h0000_0001;
        end
    end

    // clamp latched on e-stop, released in idle or off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clamp_q <= 1'b0;
        end else if (estop) begin
            clamp_q <= 1'b1;
        end else if (state_ff == dsq_pkg::ST_IDLE || state_ff == dsq_pkg::ST_OFF) begin
            clamp_q <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clamp_ff <= `DSQ_ZERO32;
        end else if (estop && !clamp_q) begin
            clamp_ff <= sfv_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tripTimer_ff <= `DSQ_ZERO32;
            trip_ff <= 1'b0;
        end else if (!estop) begin
            tripTimer_ff <= `DSQ_ZERO32;
            trip_ff <= 1'b0;
        end else if (tripTimer_ff >= 32'(`DSQ_TRIP_CYC)) begin
            trip_ff <= 1'b1;
        end else begin
            tripTimer_ff <= tripTimer_ff + 32'h0000_0001;
        end
    end

    always_comb begin
        drive.ctrlEnable = state_ff == dsq_pkg::ST_RUN;
        drive.setpointZero = state_ff != dsq_pkg::ST_RUN;
        drive.pulseBlock = state_ff != dsq_pkg::ST_RUN && state_ff != dsq_pkg::ST_STOPI;
        drive.lineContactor = !offStatus && !estop;
        drive.contactorTrip = trip_ff;
        drive.fieldReduce = autoReduce_ff | (ssField & ~optRun);
        drive.fieldClamp = clamp_q;
    end

    ////////////////////////////////////////////////////////////////
    // select outputs
    logic [63:0] sources;
    logic faultOk;
    assign faultOk = ~plant.fault;
    always_comb begin
        sources = 64'h0000_0000_0000_0000;
        sources[`DSQ_F_HIGH] = 1'b1;
        sources[`DSQ_F_FAULT] = faultOk;
        sources[`DSQ_F_RTSO] = state_ff == dsq_pkg::ST_OFF;
        sources[`DSQ_F_READY] = state_ff == dsq_pkg::ST_IDLE || state_ff == dsq_pkg::ST_BRAKEWAIT;
        sources[`DSQ_F_RUN] = state_ff == dsq_pkg::ST_RUN;
        sources[`DSQ_F_AUX] = plant.auxOn;
        sources[`DSQ_F_SUPPLY] = plant.supply;
        sources[`DSQ_F_INHIB] = ~estop;
        sources[`DSQ_F_ESTOP] = ~estop;
        sources[`DSQ_F_CHKB] = ~plant.chkback;
        sources[`DSQ_F_RAMP] = plant.rampActive;
        sources[`DSQ_F_CCW] = plant.ccw;
        sources[`DSQ_F_BRAKE] = brakeOpen_ff;
        sources[`DSQ_F_NMIN:`DSQ_F_NX1] = plant.nBelow;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gOut
            logic [63:0] srcG;
            always_comb begin
                srcG = sources;
                srcG[`DSQ_F_SET] = setOut[g];
            end
            dsq_out_filter uFilt (
                .clk(clk),
                .rst_b(rst_b),
                .funcSel(fsel_ff[8*g +: 6]),
                .invert(inv_ff[g]),
                .delayCyc(dly_ff[g]),
                .sources(srcG),
                .level(selectOut[g])
            );
        end
    endgenerate

    assign drive_status_word = {12'h000, ~faultOk, 3'h0};
    assign statusReg = {16'h0000, 4'(state_ff), estop, clamp_q, trip_ff, brakeOpen_ff, 4'h0, selectOut};
endmodule

// >>> dsq_plant_model.sv
// plant model: current, speed and indicators
`timescale 1ns/100ps
module dsq_plant_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire dsq_pkg::dsq_drive_s drive,
    input wire logic [5:0] misc,
    output dsq_pkg::dsq_plant_s plant
);
    logic [2:0] curCnt_ff;
    logic [5:0] speed_ff;
    ////////////////////////////////////////////////////////////
    // current decays slowly, so pulses wait
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) curCnt_ff <= 3'h0;
        else if (!drive.setpointZero && !drive.pulseBlock) curCnt_ff <= 3'h6;
        else if (curCnt_ff != 3'h0) curCnt_ff <= curCnt_ff - 3'h1;
    end
    // slow coast, so a holding brake must wait
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) speed_ff <= 6'h00;
        else if (drive.ctrlEnable && speed_ff < 6'h28) speed_ff <= speed_ff + 6'h01;
        else if (!drive.ctrlEnable && speed_ff != 6'h00) speed_ff <= speed_ff - 6'h01;
    end
    assign plant = '{nBelow: {6{speed_ff < 6'h08}}, rampActive: misc[5], ccw: misc[4], currentZero: curCnt_ff == 3'h0,
        supply: misc[3], auxOn: misc[2], chkback: misc[1], fault: misc[0]};
endmodule

// >>> dsq_drive_seq_monitor.sv
// port checker for the drive sequencing block
`timescale 1ns/100ps
module dsq_drive_seq_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [3:0] operEnablePins,
    input wire dsq_pkg::dsq_plant_s plant,
    input wire dsq_pkg::dsq_drive_s drive,
    input wire logic [15:0] drive_status_word
);
    logic rdPend_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rdPend_ff <= 1'b0;
        else rdPend_ff <= hsel && hready && htrans[1] && !hwrite;
    end
    ////////////////////////////////////////////////////////////
    sequence permLost; (!(&operEnablePins)) [*4]; endsequence
    sequence faultSteady; $stable(plant.fault) [*4]; endsequence
    sequence currentGone; $past(plant.currentZero) || plant.currentZero; endsequence
    chk_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
    chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    chk_rdata_idle: assert property (!rdPend_ff |-> hrdata == 32'h0000_0000) else $error("hrdata outside read");
    chk_fault_bit: assert property (faultSteady |-> drive_status_word[3] == plant.fault)
        else $error("status fault bit wrong");
    chk_perm_and: assert property (permLost |=> !drive.ctrlEnable)
        else $error("controllers on without permission");
    chk_run_pulses: assert property (drive.ctrlEnable |-> !drive.pulseBlock)
        else $error("pulses blocked while enabled");
    chk_loss_zeroset: assert property ($fell(drive.ctrlEnable) |-> drive.setpointZero)
        else $error("setpoint not zeroed on inhibit");
    chk_block_at_zero: assert property ($rose(drive.pulseBlock) |-> currentGone)
        else $error("pulses blocked with current flowing");
endmodule
bind dsq_drive_seq dsq_drive_seq_monitor u_dsq_drive_seq_monitor (.clk, .rst_b, .hsel, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .operEnablePins, .plant, .drive, .drive_status_word);

// >>> test_drive_sequence_status_outputs.sv
// self-checking bench for the drive sequencing block
`timescale 1ns/100ps
`include "dsq_defines.svh"
module test_drive_sequence_status_outputs;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, brake_release_output, standstill_field_input;
    logic estopSwitchPin, estopStopNcPin, estopResetNoPin;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [3:0] switchOnPins, operEnablePins, setOutputPins, selectOut;
    logic [5:0] misc;
    logic [7:0] obs;
    logic [15:0] drive_status_word;
    dsq_pkg::dsq_plant_s plant;
    dsq_pkg::dsq_drive_s drive;
    int bad_count, num_checks, n;
    logic [5:0] codes [16] = '{6'h07, 6'h07, 6'h08, 6'h0C, 6'h0D, 6'h0D, 6'h03, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0A,
        6'h0E, 6'h15, 6'h10, 6'h01};
    logic [5:0] lv [16] = '{6'h04, 6'h00, 6'h08, 6'h20, 6'h10, 6'h00, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
        6'h00, 6'h00, 6'h00};
    logic [15:0] expv = 16'hE99D;
    dsq_drive_seq u_dsq_drive_seq (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .switchOnPins, .operEnablePins, .estopSwitchPin,
        .estopStopNcPin, .estopResetNoPin, .standstill_field_input, .setOutputPins, .plant, .drive,
        .brake_release_output, .selectOut, .drive_status_word);
    dsq_plant_model u_dsq_plant_model (.clk, .rst_b, .drive, .misc, .plant);
    assign obs = {selectOut[0], brake_release_output, drive.ctrlEnable, drive.setpointZero, drive.pulseBlock,
        drive.fieldReduce, plant.currentZero, plant.nBelow[5]};
    ////////////////////////////////////////////////////////////
    task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // hold each phase until hready is seen high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, hsize} <= {1'b1, 2'h2, w, 3'h2};
        haddr <= {20'h0_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wt(input int b, input logic v);
        @(negedge clk);
        for (n = 0; n < 400 && obs[b] !== v; n++) @(negedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        close_out;
    end
    initial begin
        {rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata, switchOnPins, operEnablePins} = '0;
        {estopResetNoPin, standstill_field_input, setOutputPins, misc} = '0;
        {estopSwitchPin, estopStopNcPin} = 2'b11;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        bus(0, `DSQ_A_CTRL, '0);
        ck("ctrl reset", 32'h0000_0009, rd);
        bus(0, `DSQ_A_FSEL, '0);
        ck("fsel reset", 32'h0202_0203, rd);
        bus(1, 12'h100, 32'h5A5A_5A5A);
        bus(0, 12'h100, '0);
        ck("unmapped", 32'h0000_0000, rd);
        ck("outputs at reset", 32'h0000_0001, 32'(selectOut));
        $display("test reset done");
        bus(1, `DSQ_A_CTRL, 32'h0000_000A);
        bus(1, `DSQ_A_BOPEN, 32'h0000_0014);
        switchOnPins <= 4'hF;
        operEnablePins <= 4'hF;
        wt(6, 1'b1);
        ck("enable before brake", 32'h0, 32'(obs[5]));
        wt(5, 1'b1);
        ck("brake lead", 32'h1, 32'(n >= 18 && n <= 23));
        repeat (30) @(posedge clk);
        operEnablePins <= 4'hB;
        wt(5, 1'b0);
        ck("setpoint zero", 32'h1, 32'(obs[4]));
        ck("pulses wait current", 32'h0, 32'(obs[3]));
        wt(6, 1'b0);
        ck("operating brake", 32'h1, 32'(obs[3] && obs[1]));
        bus(1, `DSQ_A_BOPEN, 32'hFFFF_FFF0);
        operEnablePins <= 4'hF;
        wt(5, 1'b1);
        ck("brake closed at enable", 32'h0, 32'(obs[6]));
        wt(6, 1'b1);
        ck("brake lag", 32'h1, 32'(n >= 14 && n <= 18));
        bus(1, `DSQ_A_CTRL, 32'h0000_0009);
        repeat (50) @(posedge clk);
        operEnablePins <= 4'h0;
        wt(3, 1'b1);
        ck("holding brake open", 32'h1, 32'(obs[6]));
        wt(6, 1'b0);
        ck("holding brake at nmin", 32'h1, 32'(obs[0]));
        $display("test brake done");
        bus(1, `DSQ_A_FRDLY, 32'h0000_0028);
        switchOnPins <= 4'h0;
        wt(2, 1'b1);
        ck("auto field delay", 32'h1, 32'(n >= 38 && n < 90));
        switchOnPins <= 4'hF;
        wt(2, 1'b0);
        ck("field restore", 32'h1, 32'(n < 20));
        bus(1, `DSQ_A_CTRL, 32'h0000_0001);
        standstill_field_input <= 1'b1;
        wt(2, 1'b1);
        ck("standstill field", 32'h1, 32'(n < 10));
        bus(1, `DSQ_A_CTRL, 32'h0000_0021);
        wt(2, 1'b0);
        ck("optimization ignores", 32'h1, 32'(n < 10));
        standstill_field_input <= 1'b0;
        $display("test field done");
        bus(1, `DSQ_A_CTRL, 32'h0000_0011);
        operEnablePins <= 4'hF;
        wt(5, 1'b1);
        estopStopNcPin <= 1'b0;
        repeat (3) @(posedge clk);
        estopStopNcPin <= 1'b1;
        repeat (6) @(posedge clk);
        ck("estop inhibits", 32'h0, 32'(obs[5]));
        bus(0, `DSQ_A_STAT, '0);
        ck("estop latched", 32'h1, 32'(rd[11]));
        estopResetNoPin <= 1'b1;
        repeat (3) @(posedge clk);
        estopResetNoPin <= 1'b0;
        repeat (6) @(posedge clk);
        bus(0, `DSQ_A_STAT, '0);
        ck("estop cleared", 32'h0, 32'(rd[11]));
        bus(1, `DSQ_A_CTRL, 32'h0000_0001);
        estopSwitchPin <= 1'b0;
        repeat (6) @(posedge clk);
        bus(0, `DSQ_A_STAT, '0);
        ck("switch estop", 32'h1, 32'(rd[11]));
        estopSwitchPin <= 1'b1;
        repeat (6) @(posedge clk);
        bus(0, `DSQ_A_STAT, '0);
        ck("switch closed", 32'h0, 32'(rd[11]));
        {operEnablePins, switchOnPins} <= 8'h00;
        $display("test estop done");
        bus(1, `DSQ_A_FSEL, 32'h023F_0001);
        setOutputPins <= 4'h8;
        repeat (60) @(posedge clk);
        ck("select plain", 32'h0000_0009, 32'(selectOut));
        bus(1, `DSQ_A_INV, 32'h0000_0006);
        repeat (8) @(posedge clk);
        ck("select inverted", 32'h0000_000F, 32'(selectOut));
        bus(1, `DSQ_A_INV, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            bus(1, `DSQ_A_FSEL, {26'h000_0000, codes[i]});
            misc <= lv[i];
            repeat (8) @(posedge clk);
            ck("select code", 32'(expv[i]), 32'(selectOut[0]));
        end
        bus(1, `DSQ_A_FSEL, 32'h0000_0002);
        bus(1, `DSQ_A_DLY0, 32'h0000_000A);
        setOutputPins <= 4'h1;
        repeat (5) @(posedge clk);
        setOutputPins <= 4'h0;
        wt(7, 1'b1);
        ck("short pulse held", 32'd400, 32'(n));
        setOutputPins <= 4'h1;
        wt(7, 1'b1);
        ck("stable delay", 32'h1, 32'(n >= 10 && n <= 16));
        $display("test select done");
        close_out;
    end
endmodule
